// *** logic/pevt_pkg.sv ***
// Package: register map, field positions and carriers of the power event pin logic
package pevt_pkg;
  localparam int unsigned ADDR_W = 8;
  // Register byte offsets
  localparam logic [7:0] OFF_EVENT_CFG = 8'h00;
  localparam logic [7:0] OFF_SAG_LIMIT = 8'h04;
  localparam logic [7:0] OFF_SURGE_LIMIT = 8'h08;
  localparam logic [7:0] OFF_CUR_LIMIT = 8'h0C;
  localparam logic [7:0] OFF_POW_LIMIT = 8'h10;
  localparam logic [7:0] OFF_CTRL = 8'h14;
  localparam logic [7:0] OFF_EVENT_STAT = 8'h18;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h1C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
  localparam logic [7:0] OFF_MEAN_SQ = 8'h24;
  // Event configuration field positions
  localparam int unsigned POS_POW_PIN = 19;
  localparam int unsigned POS_CUR_PIN = 18;
  localparam int unsigned POS_VHI_PIN = 17;
  localparam int unsigned POS_VLO_PIN = 16;
  localparam int unsigned POS_MANUAL = 14;
  localparam int unsigned POS_CUR_CLR = 11;
  localparam int unsigned POS_POW_CLR = 10;
  localparam int unsigned POS_VHI_CLR = 9;
  localparam int unsigned POS_VLO_CLR = 8;
  localparam int unsigned POS_VHI_LAT = 7;
  localparam int unsigned POS_VLO_LAT = 6;
  localparam int unsigned POS_POW_LAT = 5;
  localparam int unsigned POS_CUR_LAT = 4;
  localparam int unsigned POS_VHI_SIM = 3;
  localparam int unsigned POS_VLO_SIM = 2;
  localparam int unsigned POS_POW_SIM = 1;
  localparam int unsigned POS_CUR_SIM = 0;
  // Control register field positions
  localparam int unsigned POS_MANUAL_MODE = 0;
  localparam int unsigned POS_NONE_MODE = 1;
  // Writable mask of the event configuration word; clear bits self-clear
  localparam logic [31:0] CFG_WMASK = 32'h000F_4FFF;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] LIMIT_RESET = 32'h0000_0000;
  localparam logic [31:0] SURGE_RESET = 32'hFFFF_FFFF;
  // Events in internal order: current, power, volt high, volt low
  typedef struct packed {
    logic volt_low;
    logic volt_high;
    logic power_high;
    logic current_high;
  } pevt_events_t;
  typedef struct packed {
    logic valid;
    logic [15:0] volt;
    logic [31:0] current_ms;
    logic [31:0] power;
  } pevt_meas_t;
endpackage : pevt_pkg

// *** logic/pevt_mean_square.sv ***
// Trailing half-line-cycle running mean square of voltage samples
`timescale 1ns/10ps
module pevt_mean_square #(
  parameter int unsigned DEPTH = 64,
  parameter int unsigned SAMPLE_W = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Samples
  input wire logic sample_valid,
  input wire logic signed [SAMPLE_W-1:0] sample,
  // Result
  output logic ms_valid,
  output logic [2*SAMPLE_W-1:0] trailing_volt_mean_square
);
  localparam int unsigned PTR_W = $clog2(DEPTH);
  localparam int unsigned SUM_W = 2 * SAMPLE_W + PTR_W;

  // The pointer wraps by overflow, so only powers of two keep the window exact
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("DEPTH must be a power of two of at least 2");
  end

  logic [2*SAMPLE_W-1:0] window [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [SUM_W-1:0] sum;
  logic [2*SAMPLE_W-1:0] square;

  assign square = (2*SAMPLE_W)'(sample * sample);

  // Window memory holds squares so the running sum only adds and subtracts
  always_ff @(posedge pclk) begin
    if (sample_valid) begin
      window[wr_ptr] <= square;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
    end else if (sample_valid) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  // Oldest word is unwritten after reset; the filled flag masks it out
  logic filled;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filled <= 1'b0;
    end else if (sample_valid && wr_ptr == PTR_W'(DEPTH - 1)) begin
      filled <= 1'b1;
    end
  end

  // Result carries the sample just taken, so ms_valid and the value pair up
  logic [SUM_W-1:0] next_sum;
  assign next_sum = sum + SUM_W'(square) - (filled ? SUM_W'(window[wr_ptr]) : SUM_W'(0));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sum <= '0;
    end else if (sample_valid) begin
      sum <= next_sum;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_valid <= 1'b0;
      trailing_volt_mean_square <= '0;
    end else begin
      ms_valid <= sample_valid;
      if (sample_valid) begin
        trailing_volt_mean_square <= next_sum[SUM_W-1:PTR_W];
      end
    end
  end
endmodule : pevt_mean_square

// *** logic/pevt_event_pin.sv ***
// Event detection, event configuration register and event pin control on APB
`timescale 1ns/10ps
module pevt_event_pin #(
  parameter int unsigned HALF_CYCLE_SAMPLES = 64,
  parameter int unsigned SAMPLE_W = 16
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pevt_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Measurements from the calculation engine
  input wire logic volt_sample_valid,
  input wire logic signed [SAMPLE_W-1:0] volt_sample,
  input wire pevt_pkg::pevt_meas_t meas,
  // Outputs
  output logic event_pin,
  output logic irq
);
  // ============================================================
  // Parameter checks
  if (2 * SAMPLE_W > 32) begin : g_bad_sample_w
    $error("SAMPLE_W above 16 does not fit the 32-bit limits");
  end
  // The window pointer wraps by overflow, so its depth must be a power of two
  if (HALF_CYCLE_SAMPLES < 2 || (HALF_CYCLE_SAMPLES & (HALF_CYCLE_SAMPLES - 1)) != 0) begin : g_bad_depth
    $error("HALF_CYCLE_SAMPLES must be a power of two of at least 2");
  end

  // ============================================================
  // Register state
  logic [31:0] cfg;
  logic [31:0] sag_limit;
  logic [31:0] surge_limit;
  logic [31:0] cur_limit;
  logic [31:0] pow_limit;
  logic [1:0] ctrl;
  pevt_pkg::pevt_events_t flags;
  pevt_pkg::pevt_events_t cond;
  pevt_pkg::pevt_events_t sim;
  pevt_pkg::pevt_events_t lat;
  pevt_pkg::pevt_events_t clr;
  pevt_pkg::pevt_events_t map;
  pevt_pkg::pevt_events_t irq_stat;
  pevt_pkg::pevt_events_t irq_mask;
  logic ms_valid;
  logic [2*SAMPLE_W-1:0] mean_sq;
  logic [31:0] rd_word;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // ============================================================
  // APB decode
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  always_comb begin
    unique case (paddr)
      pevt_pkg::OFF_EVENT_CFG, pevt_pkg::OFF_SAG_LIMIT, pevt_pkg::OFF_SURGE_LIMIT,
      pevt_pkg::OFF_CUR_LIMIT, pevt_pkg::OFF_POW_LIMIT, pevt_pkg::OFF_CTRL,
      pevt_pkg::OFF_EVENT_STAT, pevt_pkg::OFF_IRQ_STAT, pevt_pkg::OFF_IRQ_MASK,
      pevt_pkg::OFF_MEAN_SQ: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !addr_ok;

  function automatic logic hit(input logic [pevt_pkg::ADDR_W-1:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit

  // ============================================================
  // Event configuration register; clear bits never stored so they read back zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= pevt_pkg::CFG_RESET;
    end else if (wr_en && hit(paddr, pevt_pkg::OFF_EVENT_CFG)) begin
      cfg <= merge(cfg, pwdata, pstrb) & pevt_pkg::CFG_WMASK & ~32'h0000_0F00;
    end
  end

  // One-cycle clear pulse from a write of one to a clear bit
  always_comb begin
    clr = '0;
    if (wr_en && hit(paddr, pevt_pkg::OFF_EVENT_CFG) && pstrb[1]) begin
      clr.current_high = pwdata[pevt_pkg::POS_CUR_CLR];
      clr.power_high = pwdata[pevt_pkg::POS_POW_CLR];
      clr.volt_high = pwdata[pevt_pkg::POS_VHI_CLR];
      clr.volt_low = pwdata[pevt_pkg::POS_VLO_CLR];
    end
  end

  // Limits reset to values that keep every compare quiet until software arms them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sag_limit <= pevt_pkg::LIMIT_RESET;
    end else if (wr_en && hit(paddr, pevt_pkg::OFF_SAG_LIMIT)) begin
      sag_limit <= merge(sag_limit, pwdata, pstrb);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      surge_limit <= pevt_pkg::SURGE_RESET;
    end else if (wr_en && hit(paddr, pevt_pkg::OFF_SURGE_LIMIT)) begin
      surge_limit <= merge(surge_limit, pwdata, pstrb);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_limit <= pevt_pkg::SURGE_RESET;
    end else if (wr_en && hit(paddr, pevt_pkg::OFF_CUR_LIMIT)) begin
      cur_limit <= merge(cur_limit, pwdata, pstrb);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pow_limit <= pevt_pkg::SURGE_RESET;
    end else if (wr_en && hit(paddr, pevt_pkg::OFF_POW_LIMIT)) begin
      pow_limit <= merge(pow_limit, pwdata, pstrb);
    end
  end

  // Control: bit 0 selects the manual level, bit 1 holds the pin low when bit 0 is clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= 2'h0;
    end else if (wr_en && hit(paddr, pevt_pkg::OFF_CTRL) && pstrb[0]) begin
      ctrl <= pwdata[1:0];
    end
  end

  // ============================================================
  // Field views
  assign sim = '{volt_low: cfg[pevt_pkg::POS_VLO_SIM], volt_high: cfg[pevt_pkg::POS_VHI_SIM],
                 power_high: cfg[pevt_pkg::POS_POW_SIM], current_high: cfg[pevt_pkg::POS_CUR_SIM]};
  assign lat = '{volt_low: cfg[pevt_pkg::POS_VLO_LAT], volt_high: cfg[pevt_pkg::POS_VHI_LAT],
                 power_high: cfg[pevt_pkg::POS_POW_LAT], current_high: cfg[pevt_pkg::POS_CUR_LAT]};
  assign map = '{volt_low: cfg[pevt_pkg::POS_VLO_PIN], volt_high: cfg[pevt_pkg::POS_VHI_PIN],
                 power_high: cfg[pevt_pkg::POS_POW_PIN], current_high: cfg[pevt_pkg::POS_CUR_PIN]};

  // ============================================================
  // Voltage mean square
  pevt_mean_square #(
    .DEPTH(HALF_CYCLE_SAMPLES),
    .SAMPLE_W(SAMPLE_W)
  ) u_mean_square (
    .pclk(pclk),
    .presetn(presetn),
    .sample_valid(volt_sample_valid),
    .sample(volt_sample),
    .ms_valid(ms_valid),
    .trailing_volt_mean_square(mean_sq)
  );

  // ============================================================
  // Raw conditions, held between their evaluation instants
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cond <= '0;
    end else begin
      if (ms_valid) begin
        cond.volt_low <= 32'(mean_sq) < sag_limit;
        cond.volt_high <= 32'(mean_sq) > surge_limit;
      end
      if (meas.valid) begin
        cond.current_high <= meas.current_ms > cur_limit;
        cond.power_high <= meas.power > pow_limit;
      end
    end
  end

  // Event flags: latched ones hold until cleared, others follow the condition
  pevt_pkg::pevt_events_t raw;
  assign raw = cond | sim;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= '0;
    end else begin
      flags <= (raw & ~clr) | (flags & lat & ~clr);
    end
  end

  // ============================================================
  // Event pin
  // Registered so the pin cannot glitch while flags and map change on one edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_pin <= 1'b0;
    end else if (ctrl[pevt_pkg::POS_MANUAL_MODE]) begin
      event_pin <= cfg[pevt_pkg::POS_MANUAL];
    end else if (ctrl[pevt_pkg::POS_NONE_MODE]) begin
      event_pin <= 1'b0;
    end else begin
      event_pin <= |(flags & map);
    end
  end

  // ============================================================
  // Interrupt status: rising flags set, read clears, set wins
  pevt_pkg::pevt_events_t flags_d;
  logic stat_rd;
  logic [3:0] read_clear;
  assign stat_rd = rd_en && hit(paddr, pevt_pkg::OFF_IRQ_STAT);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_d <= '0;
    end else begin
      flags_d <= flags;
    end
  end

  // A read clears only the bits it returned, so an event set during the transfer survives
  always_comb begin
    read_clear = 4'h0;
    if (stat_rd) begin
      read_clear = prdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~read_clear) | (flags & ~flags_d);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= '0;
    end else if (wr_en && hit(paddr, pevt_pkg::OFF_IRQ_MASK) && pstrb[0]) begin
      irq_mask <= pwdata[3:0];
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ============================================================
  // Read word is captured in the setup cycle, so prdata comes from a flip-flop with no wait state
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (1'b1)
      hit(paddr, pevt_pkg::OFF_EVENT_CFG): rd_word = cfg;
      hit(paddr, pevt_pkg::OFF_SAG_LIMIT): rd_word = sag_limit;
      hit(paddr, pevt_pkg::OFF_SURGE_LIMIT): rd_word = surge_limit;
      hit(paddr, pevt_pkg::OFF_CUR_LIMIT): rd_word = cur_limit;
      hit(paddr, pevt_pkg::OFF_POW_LIMIT): rd_word = pow_limit;
      hit(paddr, pevt_pkg::OFF_CTRL): rd_word = {30'h0, ctrl};
      hit(paddr, pevt_pkg::OFF_EVENT_STAT): rd_word = {28'h0, flags};
      hit(paddr, pevt_pkg::OFF_IRQ_STAT): rd_word = {28'h0, irq_stat};
      hit(paddr, pevt_pkg::OFF_IRQ_MASK): rd_word = {28'h0, irq_mask};
      hit(paddr, pevt_pkg::OFF_MEAN_SQ): rd_word = 32'(mean_sq);
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Held through the access phase of a read only, zero otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_word;
    end else begin
      prdata <= 32'h0000_0000;
    end
  end
endmodule : pevt_event_pin

// *** verification/pevt_pin_sink.sv ***
// Model of the interrupt input that watches the event pin
`timescale 1ns/10ps
module pevt_pin_sink (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Event pin
  input wire logic event_pin,
  // Observed level and rising edges
  output logic seen,
  output int rises
);
  // Registered like a real input stage, so short glitches never count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen <= 1'b0;
      rises <= 0;
    end else begin
      seen <= event_pin;
      if (event_pin && !seen) begin
        rises <= rises + 1;
      end
    end
  end
endmodule : pevt_pin_sink

// *** verification/pevt_event_pin_chk.sv ***
// Concurrent checks on the ports of the event pin logic
`timescale 1ns/10ps
module pevt_event_pin_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pevt_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Outputs
  input wire logic event_pin,
  input wire logic irq
);
  logic acc;
  logic [31:0] cfg;
  logic [31:0] ctrl;
  logic [31:0] mask;
  assign acc = psel && penable;
  // Shadows of the steering registers; assumes full-word writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= 32'h0000_0000;
      ctrl <= 32'h0000_0000;
      mask <= 32'h0000_0000;
    end else if (acc && pwrite) begin
      if (paddr == pevt_pkg::OFF_EVENT_CFG) cfg <= pwdata;
      if (paddr == pevt_pkg::OFF_CTRL) ctrl <= pwdata;
      if (paddr == pevt_pkg::OFF_IRQ_MASK) mask <= pwdata;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_now_a: assert property (acc |-> pready) else $error("pready low in access phase");
  rd_idle_a: assert property (!(acc && !pwrite) |-> prdata == 32'h0000_0000) else $error("prdata outside read");
  cfg_rsvd_a: assert property (acc && !pwrite && paddr == pevt_pkg::OFF_EVENT_CFG |->
    (prdata & 32'hFFF0_BF00) == 32'h0000_0000) else $error("reserved or clear bits read as one");
  bad_addr_a: assert property (acc |-> pslverr == (paddr[1:0] != 2'b00 || paddr > 8'h24))
    else $error("pslverr wrong for address");
  man_pin_a: assert property ($past(ctrl[1:0]) == 2'b01 |-> event_pin == $past(cfg[14]))
    else $error("manual level not on pin");
  none_pin_a: assert property ($past(ctrl[1:0]) == 2'b10 |-> !event_pin)
    else $error("pin high with no event mode");
  unmap_pin_a: assert property ($past(ctrl[1:0]) == 2'b00 && $past(cfg[19:16]) == 4'h0 |-> !event_pin)
    else $error("pin high with nothing mapped");
  sim_pin_a: assert property ($rose(cfg[1] && cfg[19]) && ctrl[1:0] == 2'b00 |-> ##[1:4] event_pin)
    else $error("simulated mapped event missing on pin");
  irq_mask_a: assert property (mask[3:0] == 4'h0 |-> !irq) else $error("irq with all masked");
endmodule : pevt_event_pin_chk
bind pevt_event_pin pevt_event_pin_chk pevt_event_pin_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .event_pin(event_pin), .irq(irq));

// *** verification/pevt_event_pin_tb_top.sv ***
// Self-checking bench of the power event pin logic
`timescale 1ns/10ps
module pevt_event_pin_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, event_pin, irq, vs_valid, seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, ms;
  logic [3:0] pstrb;
  logic signed [15:0] vs;
  pevt_pkg::pevt_meas_t meas;
  logic [31:0] expq[$];
  int bad_count, total_checks, rises;
  int sv[4];
  pevt_event_pin #(.HALF_CYCLE_SAMPLES(4)) pevt_event_pin_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .volt_sample_valid(vs_valid), .volt_sample(vs), .meas(meas),
    .event_pin(event_pin), .irq(irq));
  pevt_pin_sink pevt_pin_sink_i (.pclk(pclk), .presetn(presetn), .event_pin(event_pin), .seen(seen),
    .rises(rises));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    if (bad_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic pin(input logic e);
    repeat (6) @(posedge pclk);
    chk({31'h0, seen}, {31'h0, e});
  endtask : pin
  task automatic mpulse(input logic [31:0] c);
    meas.current_ms <= c;
    meas.valid <= 1'b1;
    @(posedge pclk);
    meas.valid <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : mpulse
  // Monitor takes the oldest noted value at each completed read
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      chk(prdata, expq.pop_front());
    end
  end
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end
  initial begin
    {presetn, psel, penable, pwrite, vs_valid} = 5'h00;
    {paddr, pwdata, vs, meas} = '0;
    pstrb = 4'hF;
    void'($urandom(32));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(pevt_pkg::OFF_EVENT_CFG, 32'h0000_0000);
    rd(pevt_pkg::OFF_SURGE_LIMIT, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0000_0000);
    apb(1'b1, pevt_pkg::OFF_IRQ_MASK, 32'h0000_000F);
    apb(1'b1, pevt_pkg::OFF_EVENT_CFG, 32'hFFFF_FFFF);
    rd(pevt_pkg::OFF_EVENT_CFG, 32'h000F_40FF);
    rd(pevt_pkg::OFF_EVENT_STAT, 32'h0000_000F);
    pin(1'b1);
    chk({31'h0, irq}, 32'h0000_0001);
    rd(pevt_pkg::OFF_IRQ_STAT, 32'h0000_000F);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1'b1, pevt_pkg::OFF_EVENT_CFG, 32'h0000_0F00);
    rd(pevt_pkg::OFF_EVENT_STAT, 32'h0000_0000);
    apb(1'b1, pevt_pkg::OFF_EVENT_CFG, 32'h0008_0022);
    apb(1'b1, pevt_pkg::OFF_EVENT_CFG, 32'h0008_0020);
    rd(pevt_pkg::OFF_EVENT_STAT, 32'h0000_0002);
    pin(1'b1);
    apb(1'b1, pevt_pkg::OFF_EVENT_CFG, 32'h0008_0420);
    rd(pevt_pkg::OFF_EVENT_STAT, 32'h0000_0000);
    rd(pevt_pkg::OFF_EVENT_CFG, 32'h0008_0020);
    pin(1'b0);
    apb(1'b1, pevt_pkg::OFF_CUR_LIMIT, 32'h0000_0100);
    apb(1'b1, pevt_pkg::OFF_EVENT_CFG, 32'h0004_0000);
    mpulse(32'h0000_0101);
    rd(pevt_pkg::OFF_EVENT_STAT, 32'h0000_0001);
    pin(1'b1);
    mpulse(32'h0000_0100);
    rd(pevt_pkg::OFF_EVENT_STAT, 32'h0000_0000);
    ms = 32'h0000_0000;
    foreach (sv[i]) begin
      sv[i] = $urandom_range(255, 1);
      ms += 32'(sv[i] * sv[i]);
    end
    ms = ms >> 2;
    apb(1'b1, pevt_pkg::OFF_SURGE_LIMIT, ms - 32'h0000_0001);
    apb(1'b1, pevt_pkg::OFF_SAG_LIMIT, ms + 32'h0000_0001);
    apb(1'b1, pevt_pkg::OFF_EVENT_CFG, 32'h0003_0000);
    foreach (sv[i]) begin
      vs <= 16'(sv[i]);
      vs_valid <= 1'b1;
      @(posedge pclk);
      vs_valid <= 1'b0;
      @(posedge pclk);
    end
    rd(pevt_pkg::OFF_MEAN_SQ, ms);
    rd(pevt_pkg::OFF_EVENT_STAT, 32'h0000_000C);
    apb(1'b1, pevt_pkg::OFF_CTRL, 32'h0000_0001);
    apb(1'b1, pevt_pkg::OFF_EVENT_CFG, 32'h0003_4000);
    pin(1'b1);
    apb(1'b1, pevt_pkg::OFF_EVENT_CFG, 32'h0003_0000);
    pin(1'b0);
    apb(1'b1, pevt_pkg::OFF_CTRL, 32'h0000_0002);
    pin(1'b0);
    apb(1'b1, pevt_pkg::OFF_CTRL, 32'h0000_0000);
    pin(1'b1);
    chk(32'(rises), 32'h0000_0006);
    wrap_up();
  end
endmodule : pevt_event_pin_tb_top
